// *** cta_top.sv ***
`timescale 1ns/100ps
module cta_top (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic cyc_valid,
	input wire logic [cta_pkg::ADDR_W-1:0] cyc_addr,
	input wire logic [cta_pkg::DATA_W-1:0] cyc_data,
	input wire logic [cta_pkg::CTRL_W-1:0] cyc_ctrl,
	output logic triggered,
	output logic capture_done
);
	import cta_pkg::*;

	logic rst_meta, rst_n;
	logic a_pend, a_write, a_hit, acc, wr_en, rd_en, arm_pulse, disarm_pulse;
	logic [7:0] a_addr;
	logic [31:0] rd_mux;
	cta_comb_e comb_mode;
	cta_cap_e cap_mode;
	cta_tmr_e tmr_mode;
	logic q_en, armed, running, fire, fire_evt, store_en, qual_hit, b2b_hit;
	logic [SMP_W-1:0] sample, q_val, q_care;
	logic [SMP_W-1:0] u_val [3];
	logic [SMP_W-1:0] u_care [3];
	logic [3:0] u_rep [3];
	logic [3:0] cnt [3];
	logic [2:0] u_en, raw, sat, active, done_u, ok;
	logic [1:0] stage;
	logic d1, d2;
	logic [SMP_W-1:0] trace_mem [TRACE_DEPTH];
	logic [PTR_W-1:0] wr_ptr, trig_idx, post_left, trace_sel;
	logic [DIV_W-1:0] div;
	logic us_tick, gate, tmr_run, tmr_done, t_on, t_gated, t_restart, tmr_start, tmr_stop;
	logic [15:0] mant;
	logic [2:0] expo;
	logic [31:0] pre;

	// Per-bit compare: a set care bit demands equality, a clear one ignores the bit.
	function automatic logic bit_match(input logic [SMP_W-1:0] s, input logic [SMP_W-1:0] v,
		input logic [SMP_W-1:0] c);
		return ((s ^ v) & c) == '0;
	endfunction : bit_match

	// A programmed count of zero behaves as one occurrence.
	function automatic logic [4:0] rep_target(input logic [3:0] c);
		return (c == 4'h0) ? 5'h01 : {1'b0, c};
	endfunction : rep_target

	// First enabled unit at or after a position; three means none is left.
	function automatic logic [1:0] first_en(input logic [2:0] en, input logic [2:0] from);
		logic [1:0] r;
		r = 2'h3;
		for (int i = 2; i >= 0; i--)
		begin
			if (en[i] && (3'(i) >= from))
				r = 2'(i);
		end
		return r;
	endfunction : first_en

	// Length of one timer step in microseconds at a given range.
	function automatic logic [31:0] unit_len(input logic [2:0] e);
		return 32'h1 << {e, 2'b00};
	endfunction : unit_len

	// Reset release through two flops; only the second one is used.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Bus slave: every transfer takes one wait state, reads are registered.
	assign acc = hsel && htrans[1] && hready;
	assign wr_en = a_pend && a_write && a_hit;
	assign rd_en = a_pend && !a_write;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_pend <= 1'b0;
			a_write <= 1'b0;
			a_hit <= 1'b0;
			a_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
		end
		else
		begin
			hresp <= 1'b0;
			if (acc)
			begin
				a_pend <= 1'b1;
				a_write <= hwrite;
				a_hit <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
				a_addr <= haddr[7:0];
				hreadyout <= 1'b0;
			end
			else if (a_pend)
			begin
				a_pend <= 1'b0;
				hreadyout <= 1'b1;
				if (rd_en)
					hrdata <= a_hit ? rd_mux : 32'h00000000;
			end
		end
	end

	// Read multiplexer; unmapped words read as zero.
	always_comb
	begin
		rd_mux = 32'h00000000;
		case (a_addr)
			OFF_CTRL: rd_mux = {21'h0, tmr_mode, 2'h0, q_en, cap_mode, comb_mode};
			OFF_CMD: rd_mux = {25'h0, gate, stage, tmr_run, capture_done, triggered, armed};
			OFF_TRACE_INFO: rd_mux = {16'h0, trig_idx, wr_ptr};
			OFF_TIMER: rd_mux = {13'h0, expo, mant};
			OFF_QUAL_VAL: rd_mux = q_val;
			OFF_QUAL_CARE: rd_mux = q_care;
			OFF_TRACE_SEL: rd_mux = {24'h0, trace_sel};
			OFF_TRACE_DATA: rd_mux = trace_mem[trace_sel];
			default:
			begin
				for (int u = 0; u < 3; u++)
				begin
					if (a_addr[7:4] == UNIT_BASE_HI + 4'(u))
					begin
						if (a_addr[3:0] == OFF_UNIT_VAL)
							rd_mux = u_val[u];
						else if (a_addr[3:0] == OFF_UNIT_CARE)
							rd_mux = u_care[u];
						else if (a_addr[3:0] == OFF_UNIT_CFG)
							rd_mux = {24'h0, u_rep[u], 3'h0, u_en[u]};
					end
				end
			end
		endcase
	end

	// Software-written setup registers and the arm and disarm command pulses.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			comb_mode <= comb_any;
			cap_mode <= cap_start;
			tmr_mode <= tmr_off;
			q_en <= 1'b0;
			q_val <= '0;
			q_care <= '0;
			trace_sel <= '0;
			u_en <= 3'h0;
			arm_pulse <= 1'b0;
			disarm_pulse <= 1'b0;
			for (int u = 0; u < 3; u++)
			begin
				u_val[u] <= '0;
				u_care[u] <= '0;
				u_rep[u] <= 4'h0;
			end
		end
		else
		begin
			arm_pulse <= wr_en && (a_addr == OFF_CMD) && hwdata[CMD_ARM_BIT];
			disarm_pulse <= wr_en && (a_addr == OFF_CMD) && hwdata[CMD_DISARM_BIT];
			if (wr_en)
			begin
				case (a_addr)
					OFF_CTRL:
					begin
						comb_mode <= cta_comb_e'(hwdata[CTRL_MODE_LSB +: 3]);
						cap_mode <= cta_cap_e'(hwdata[CTRL_CAP_LSB +: 2]);
						q_en <= hwdata[CTRL_QEN_BIT];
						tmr_mode <= cta_tmr_e'(hwdata[CTRL_TMR_LSB +: 3]);
					end
					OFF_QUAL_VAL: q_val <= hwdata;
					OFF_QUAL_CARE: q_care <= hwdata;
					OFF_TRACE_SEL: trace_sel <= hwdata[PTR_W-1:0];
					default:
					begin
						for (int u = 0; u < 3; u++)
						begin
							if (a_addr[7:4] == UNIT_BASE_HI + 4'(u))
							begin
								if (a_addr[3:0] == OFF_UNIT_VAL)
									u_val[u] <= hwdata;
								else if (a_addr[3:0] == OFF_UNIT_CARE)
									u_care[u] <= hwdata;
								else if (a_addr[3:0] == OFF_UNIT_CFG)
								begin
									u_en[u] <= hwdata[CFG_EN_BIT];
									u_rep[u] <= hwdata[CFG_CNT_LSB +: 4];
								end
							end
						end
					end
				endcase
			end
		end
	end

	// Match units and the combined trigger decision.
	assign sample = {cyc_ctrl, cyc_data, cyc_addr};
	assign qual_hit = bit_match(sample, q_val, q_care);
	assign running = armed && !triggered;
	always_comb
	begin
		for (int u = 0; u < 3; u++)
		begin
			raw[u] = bit_match(sample, u_val[u], u_care[u]);
			ok[u] = !u_en[u] || raw[u];
			case (comb_mode)
				ordered_sequence_mode: active[u] = (stage == 2'(u));
				back_to_back_sequence_mode: active[u] = 1'b0;
				default: active[u] = u_en[u];
			endcase
			done_u[u] = cyc_valid && running && active[u] && raw[u] && !sat[u]
				&& ({1'b0, cnt[u]} + 5'h01 >= rep_target(u_rep[u]));
		end
		b2b_hit = cyc_valid && running && (|u_en) && (u_en[2] ? (d2 && raw[2]) : (d1 && ok[1]));
		case (comb_mode)
			comb_any: fire = |(sat & u_en);
			comb_all: fire = (&u_en) && (&sat);
			ordered_sequence_mode: fire = (stage == 2'h3) && (|u_en);
			back_to_back_sequence_mode: fire = b2b_hit;
			either_then_both_mode: fire = u_en[2] && sat[2] && ((u_en[0] && sat[0]) || (u_en[1] && sat[1]));
			default: fire = 1'b0;
		endcase
	end
	assign fire_evt = running && fire && !arm_pulse;

	// Repeat counters, sequence progress and the back-to-back chain; cleared on arming.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sat <= 3'h0;
			stage <= 2'h0;
			d1 <= 1'b0;
			d2 <= 1'b0;
			for (int u = 0; u < 3; u++)
				cnt[u] <= 4'h0;
		end
		else if (arm_pulse)
		begin
			sat <= 3'h0;
			stage <= first_en(u_en, 3'h0);
			d1 <= 1'b0;
			d2 <= 1'b0;
			for (int u = 0; u < 3; u++)
				cnt[u] <= 4'h0;
		end
		else if (cyc_valid && running)
		begin
			d1 <= ok[0];
			d2 <= d1 && ok[1];
			for (int u = 0; u < 3; u++)
			begin
				if (done_u[u])
					sat[u] <= 1'b1;
				else if (active[u] && raw[u] && !sat[u])
					cnt[u] <= cnt[u] + 4'h1;
			end
			if ((comb_mode == ordered_sequence_mode) && (stage != 2'h3) && done_u[stage])
				stage <= first_en(u_en, {1'b0, stage} + 3'h1);
		end
	end

	// Armed and triggered flags.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			armed <= 1'b0;
			triggered <= 1'b0;
		end
		else
		begin
			if (arm_pulse)
				armed <= 1'b1;
			else if (disarm_pulse || capture_done)
				armed <= 1'b0;
			if (arm_pulse)
				triggered <= 1'b0;
			else if (fire_evt)
				triggered <= 1'b1;
		end
	end

	// Trace buffer: qualified cycles go in circularly until the post-trigger share is filled.
	assign store_en = cyc_valid && armed && !capture_done && (!q_en || qual_hit);
	always_ff @(posedge mclk)
	begin
		if (store_en)
			trace_mem[wr_ptr] <= sample;
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			trig_idx <= '0;
			post_left <= '0;
			capture_done <= 1'b0;
		end
		else if (arm_pulse)
		begin
			wr_ptr <= '0;
			post_left <= '0;
			capture_done <= 1'b0;
		end
		else
		begin
			if (store_en)
				wr_ptr <= wr_ptr + 8'h01;
			if (fire_evt)
			begin
				trig_idx <= wr_ptr;
				case (cap_mode)
					cap_start: post_left <= POST_START;
					cap_centre: post_left <= POST_CENTRE;
					cap_end: capture_done <= 1'b1;
					default: post_left <= POST_START;
				endcase
			end
			else if (store_en && triggered)
			begin
				if (post_left == '0)
					capture_done <= 1'b1;
				else
					post_left <= post_left - 8'h01;
			end
		end
	end

	// Microsecond time base; a start realigns it so start and stop stay exact.
	assign us_tick = (div == DIV_W'(TICK_CYC - 1));
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			div <= '0;
		else if (tmr_start || us_tick)
			div <= '0;
		else
			div <= div + 7'h01;
	end

	// Interval timer: start and stop events, the gate, and the autoranging counter.
	assign t_on = armed && (tmr_mode != tmr_off);
	assign t_gated = (tmr_mode == tmr_gated) || (tmr_mode == gated_restart_timing);
	assign t_restart = (tmr_mode == auto_restart_timing) || (tmr_mode == gated_restart_timing);
	assign tmr_start = cyc_valid && t_on && (t_gated ? (raw[1] && gate) : raw[0])
		&& (t_restart || (!tmr_run && !tmr_done));
	assign tmr_stop = cyc_valid && t_on && tmr_run && raw[2] && !tmr_start;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			gate <= 1'b0;
		else if (arm_pulse)
			gate <= 1'b0;
		else if (cyc_valid && t_on && t_gated)
		begin
			if (raw[0])
				gate <= 1'b1;
			else if (raw[2])
				gate <= 1'b0;
		end
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tmr_run <= 1'b0;
			tmr_done <= 1'b0;
			mant <= 16'h0000;
			expo <= 3'h0;
			pre <= 32'h00000000;
		end
		else if (arm_pulse)
		begin
			tmr_run <= 1'b0;
			tmr_done <= 1'b0;
			mant <= 16'h0000;
			expo <= 3'h0;
			pre <= 32'h00000000;
		end
		else if (tmr_start)
		begin
			tmr_run <= 1'b1;
			tmr_done <= 1'b0;
			mant <= 16'h0000;
			expo <= 3'h0;
			pre <= 32'h00000000;
		end
		else if (tmr_stop)
		begin
			tmr_run <= 1'b0;
			tmr_done <= 1'b1;
		end
		else if (tmr_run && us_tick)
		begin
			if (pre == unit_len(expo) - 32'h1)
			begin
				pre <= 32'h00000000;
				if (mant != MANT_MAX)
					mant <= mant + 16'h0001;
				else if (expo != EXP_MAX)
				begin
					mant <= MANT_RESCALED;
					expo <= expo + 3'h1;
				end
			end
			else
				pre <= pre + 32'h1;
		end
	end

	// Checks of the behaviour above.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence ahb_wait_s;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence tick_gap_s;
		!us_tick [*8];
	endsequence

	bus_wait_state_a: assert property (acc |=> ahb_wait_s) else $error("bus answer not after one wait state");
	arm_clears_a: assert property (arm_pulse |=> (sat == 3'h0) && !triggered && !d1)
		else $error("arming did not clear progress");
	trig_sticky_a: assert property (triggered && !arm_pulse |=> triggered)
		else $error("triggered flag dropped without arming");
	fire_sets_a: assert property (fire_evt |=> triggered) else $error("trigger fired but flag not set");
	all_mode_a: assert property ((comb_mode == comb_all) && !(&u_en) |-> !fire)
		else $error("all-match fired with a unit disabled");
	b2b_count_a: assert property ((comb_mode == back_to_back_sequence_mode) && !arm_pulse |=> $stable(sat))
		else $error("repeat counting in back-to-back mode");
	order_stage_a: assert property ((comb_mode == ordered_sequence_mode) && running && (stage == 2'h1)
		|-> sat[0] || !u_en[0]) else $error("unit B checked before unit A");
	qual_store_a: assert property (store_en |-> !q_en || qual_hit) else $error("unqualified cycle stored");
	cap_end_a: assert property (fire_evt && (cap_mode == cap_end) |=> capture_done)
		else $error("end capture did not stop at trigger");
	tick_period_a: assert property (us_tick && !tmr_start |=> tick_gap_s)
		else $error("time base ticks too fast");
	start_align_a: assert property (tmr_start |=> (div == '0) && tmr_run && (mant == 16'h0000))
		else $error("timer start not aligned");
	autorange_a: assert property (tmr_run && us_tick && !tmr_start && !tmr_stop && (mant == MANT_MAX)
		&& (expo != EXP_MAX) && (pre == unit_len(expo) - 32'h1)
		|=> (mant == MANT_RESCALED) && (expo == $past(expo) + 3'h1))
		else $error("timer did not rescale by sixteen");
endmodule : cta_top

// *** cta_pkg.sv ***
package cta_pkg;
	// Clock and time base.
	localparam int CLK_NS = 10;
	localparam int US_NS = 1000;
	localparam int TICK_CYC = US_NS / CLK_NS;
	localparam int DIV_W = 7;
	// Target cycle sample layout.
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int CTRL_W = 8;
	localparam int SMP_W = ADDR_W + DATA_W + CTRL_W;
	// Trace buffer.
	localparam int PTR_W = 8;
	localparam int TRACE_DEPTH = 256;
	localparam logic [PTR_W-1:0] POST_START = 8'hFE;
	localparam logic [PTR_W-1:0] POST_CENTRE = 8'h7F;
	// Register offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_TRACE_INFO = 8'h08;
	localparam logic [7:0] OFF_TIMER = 8'h0C;
	localparam logic [3:0] UNIT_BASE_HI = 4'h1;
	localparam logic [3:0] OFF_UNIT_VAL = 4'h0;
	localparam logic [3:0] OFF_UNIT_CARE = 4'h4;
	localparam logic [3:0] OFF_UNIT_CFG = 4'h8;
	localparam logic [7:0] OFF_QUAL_VAL = 8'h40;
	localparam logic [7:0] OFF_QUAL_CARE = 8'h44;
	localparam logic [7:0] OFF_TRACE_SEL = 8'h48;
	localparam logic [7:0] OFF_TRACE_DATA = 8'h4C;
	// Control field positions.
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_CAP_LSB = 3;
	localparam int CTRL_QEN_BIT = 5;
	localparam int CTRL_TMR_LSB = 8;
	localparam int CMD_ARM_BIT = 0;
	localparam int CMD_DISARM_BIT = 1;
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_CNT_LSB = 4;
	// Timer layout.
	localparam logic [15:0] MANT_MAX = 16'hFFFF;
	localparam logic [15:0] MANT_RESCALED = 16'h1000;
	localparam logic [2:0] EXP_MAX = 3'h7;
	typedef enum logic [2:0] {comb_any, comb_all, ordered_sequence_mode, back_to_back_sequence_mode,
		either_then_both_mode} cta_comb_e;
	typedef enum logic [1:0] {cap_start, cap_centre, cap_end} cta_cap_e;
	typedef enum logic [2:0] {tmr_off, tmr_auto, tmr_gated, auto_restart_timing, gated_restart_timing} cta_tmr_e;
endpackage : cta_pkg

// *** cta_cyc_model.sv ***
`timescale 1ns/100ps
// Stands in for the target processor, offering one machine cycle per clock.
module cta_cyc_model (
	input wire logic mclk,
	output logic cyc_valid,
	output logic [cta_pkg::ADDR_W-1:0] cyc_addr,
	output logic [cta_pkg::DATA_W-1:0] cyc_data,
	output logic [cta_pkg::CTRL_W-1:0] cyc_ctrl
);
	import cta_pkg::*;
	// Lines start quiet.
	initial
	begin
		cyc_valid = 1'b0;
		cyc_addr = 16'h0000;
		cyc_data = 8'h00;
		cyc_ctrl = 8'h00;
	end
	// One slot per edge; idle slots flip the lines so stale samples never look held.
	task automatic step(input logic v, input logic [ADDR_W-1:0] a, input logic [CTRL_W-1:0] c);
		cyc_valid <= v;
		cyc_addr <= v ? a : ~cyc_addr;
		cyc_data <= v ? 8'h5A : ~cyc_data;
		cyc_ctrl <= v ? c : ~cyc_ctrl;
		@(posedge mclk);
	endtask : step
endmodule : cta_cyc_model

// *** cta_tb_top.sv ***
`timescale 1ns/100ps
module cta_tb_top;
	import cta_pkg::*;
	logic mclk;
	logic nrst;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic cyc_valid;
	logic [ADDR_W-1:0] cyc_addr;
	logic [DATA_W-1:0] cyc_data;
	logic [CTRL_W-1:0] cyc_ctrl;
	logic triggered;
	logic capture_done;
	logic [31:0] rd;
	int bad_count;
	int num_checks;
	localparam logic [15:0] AA = 16'h0A00;
	localparam logic [15:0] AB = 16'h0B00;
	localparam logic [15:0] AC = 16'h0C00;
	localparam logic [15:0] AN = 16'h0F00;
	localparam logic [31:0] EN = 32'h11;
	localparam logic [31:0] DIS = 32'h10;
	localparam logic [31:0] C3 = 32'h31;

	cta_top dut_u (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_data(cyc_data), .cyc_ctrl(cyc_ctrl),
		.triggered(triggered), .capture_done(capture_done));

	cta_cyc_model model_u (.mclk(mclk), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_data(cyc_data),
		.cyc_ctrl(cyc_ctrl));

	// Free-running 100 MHz clock.
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Prints the counts and the verdict, then stops.
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	// One counted comparison.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Waits for hready at a rising edge, bounded.
	task automatic wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (hready !== 1'b1 && n < 40);
		if (n >= 40)
		begin
			bad_count++;
			wrap_up();
		end
	endtask : wait_ready

	// Single word transfer: address phase, then data phase; read data lands in rd.
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : bus

	task automatic idle;
		model_u.step(1'b0, 16'h0000, 8'h00);
	endtask : idle

	task automatic cyc(input logic [15:0] a);
		model_u.step(1'b1, a, 8'h01);
	endtask : cyc

	function automatic logic [31:0] mk(input logic [2:0] m, input logic [1:0] c, input logic q,
		input logic [2:0] t);
		return {21'h0, t, 2'b00, q, c, m};
	endfunction : mk

	// Programs mode and unit configs, then arms.
	task automatic arm(input logic [31:0] ctl, input logic [31:0] fa, fb, fc);
		bus(1'b1, 32'h00, ctl);
		bus(1'b1, 32'h18, fa);
		bus(1'b1, 32'h28, fb);
		bus(1'b1, 32'h38, fc);
		bus(1'b1, 32'h04, 32'h1);
		repeat (2) idle();
	endtask : arm

	// Lets the registered fire land, then judges the sticky flag.
	task automatic trig(input logic e);
		repeat (4) idle();
		chk(triggered, e, "triggered");
	endtask : trig

	// Arms, plays four cycles (first in the top slice), judges the trigger.
	task automatic run(input logic [31:0] ctl, input logic [31:0] fa, fb, fc, input logic [63:0] p, input logic e);
		arm(ctl, fa, fb, fc);
		for (int i = 3; i >= 0; i--)
			cyc(p[16*i +: 16]);
		trig(e);
	endtask : run

	// Reset state, unmapped place, and unit match patterns on the address only.
	task automatic t_reset;
		chk(hready, 1'b1, "idle ready");
		chk(triggered, 1'b0, "trig at reset");
		chk(capture_done, 1'b0, "done at reset");
		bus(1'b1, 32'h3C, 32'hFFFFFFFF);
		chk(hresp, 1'b0, "okay");
		bus(1'b0, 32'h3C, 32'h0);
		chk(rd, 32'h0, "unmapped");
		bus(1'b1, 32'h10, {16'h0, AA});
		bus(1'b1, 32'h20, {16'h0, AB});
		bus(1'b1, 32'h30, {16'h0, AC});
		for (int u = 1; u < 4; u++)
			bus(1'b1, 32'(u * 16 + 4), 32'h0000FFFF);
		bus(1'b1, 32'h40, 32'h01000000);
		bus(1'b1, 32'h44, 32'h01000000);
	endtask : t_reset

	// Repeat count, re-arm clearing flag and count, any-match on unit C, and a disabled unit B ignored.
	task automatic t_count;
		run(mk(comb_any, cap_start, 1'b0, tmr_off), C3, DIS, DIS, {AA, AN, AA, AN}, 1'b0);
		cyc(AA);
		trig(1'b1);
		arm(mk(comb_any, cap_start, 1'b0, tmr_off), C3, DIS, DIS);
		chk(triggered, 1'b0, "rearm clears");
		cyc(AA);
		cyc(AA);
		trig(1'b0);
		run(mk(comb_any, cap_start, 1'b0, tmr_off), DIS, EN, EN, {AN, AN, AN, AC}, 1'b1);
		run(mk(comb_any, cap_start, 1'b0, tmr_off), EN, DIS, EN, {AN, AB, AN, AN}, 1'b0);
	endtask : t_count

	task automatic t_all;
		run(mk(comb_all, cap_start, 1'b0, tmr_off), EN, EN, EN, {AN, AA, AB, AN}, 1'b0);
		run(mk(comb_all, cap_start, 1'b0, tmr_off), EN, EN, EN, {AC, AB, AN, AA}, 1'b1);
		run(mk(comb_all, cap_start, 1'b0, tmr_off), EN, EN, DIS, {AA, AB, AC, AC}, 1'b0);
	endtask : t_all

	task automatic t_ord;
		run(mk(ordered_sequence_mode, cap_start, 1'b0, tmr_off), EN, EN, EN, {AB, AA, AC, AB}, 1'b0);
		run(mk(ordered_sequence_mode, cap_start, 1'b0, tmr_off), EN, EN, EN, {AA, AB, AN, AC}, 1'b1);
		run(mk(ordered_sequence_mode, cap_start, 1'b0, tmr_off), EN, DIS, EN, {AN, AA, AN, AC}, 1'b1);
		run(mk(ordered_sequence_mode, cap_start, 1'b0, tmr_off), DIS, EN, EN, {AN, AN, AB, AC}, 1'b1);
	endtask : t_ord

	task automatic t_b2b;
		run(mk(back_to_back_sequence_mode, cap_start, 1'b0, tmr_off), C3, C3, C3, {AA, AN, AB, AC}, 1'b0);
		run(mk(back_to_back_sequence_mode, cap_start, 1'b0, tmr_off), C3, C3, C3, {AN, AA, AB, AC}, 1'b1);
		run(mk(back_to_back_sequence_mode, cap_start, 1'b0, tmr_off), EN, DIS, EN, {AA, AN, AC, AN}, 1'b1);
		run(mk(back_to_back_sequence_mode, cap_start, 1'b0, tmr_off), EN, DIS, EN, {AN, AA, AC, AN}, 1'b0);
	endtask : t_b2b

	task automatic t_etb;
		run(mk(either_then_both_mode, cap_start, 1'b0, tmr_off), EN, EN, EN, {AN, AN, AB, AC}, 1'b1);
		run(mk(either_then_both_mode, cap_start, 1'b0, tmr_off), EN, EN, EN, {AN, AN, AN, AC}, 1'b0);
		run(mk(either_then_both_mode, cap_start, 1'b0, tmr_off), EN, EN, EN, {AA, AB, AN, AN}, 1'b0);
		run(mk(either_then_both_mode, cap_start, 1'b0, tmr_off), 32'h21, EN, EN, {AN, AA, AN, AC}, 1'b0);
	endtask : t_etb

	// Stored-cycle counts with and without the store qualifier.
	task automatic t_qual;
		logic [7:0] p0;
		for (int q = 1; q >= 0; q--)
		begin
			arm(mk(comb_any, cap_end, q[0], tmr_off), DIS, DIS, DIS);
			bus(1'b0, 32'h08, 32'h0);
			p0 = rd[7:0];
			repeat (3) model_u.step(1'b1, AN, 8'h01);
			repeat (2) model_u.step(1'b1, AN, 8'h00);
			repeat (2) idle();
			bus(1'b0, 32'h08, 32'h0);
			chk(32'(rd[7:0] - p0), q ? 32'd3 : 32'd5, "stored count");
		end
	endtask : t_qual

	// Capture ends 255, 128 or 0 stores after the fire.
	task automatic t_cap;
		int left[3] = '{255, 128, 0};
		for (int c = 0; c < 3; c++)
		begin
			arm(mk(comb_any, 2'(c), 1'b0, tmr_off), EN, DIS, DIS);
			cyc(AA);
			repeat (2) idle();
			repeat (left[c] - 1) cyc(AN);
			repeat (2) idle();
			if (left[c] > 0)
				chk(capture_done, 1'b0, "done early");
			cyc(AN);
			repeat (3) idle();
			chk(capture_done, 1'b1, "done");
		end
	endtask : t_cap

	// Status and control readback, trigger index, stored sample, and disarm refusing further stores.
	task automatic t_misc;
		arm(mk(comb_any, cap_start, 1'b0, tmr_off), EN, DIS, DIS);
		bus(1'b0, 32'h00, 32'h0);
		chk(rd, mk(comb_any, cap_start, 1'b0, tmr_off), "control readback");
		bus(1'b0, 32'h04, 32'h0);
		chk(rd, 32'h01, "armed status");
		cyc(AA);
		repeat (3) idle();
		bus(1'b0, 32'h04, 32'h0);
		chk(rd, 32'h03, "triggered status");
		bus(1'b0, 32'h08, 32'h0);
		chk(rd, 32'h0101, "trigger index");
		bus(1'b1, 32'h48, 32'h0);
		bus(1'b0, 32'h4C, 32'h0);
		chk(rd, {8'h01, 8'h5A, AA}, "stored sample");
		bus(1'b1, 32'h04, 32'h2);
		bus(1'b0, 32'h04, 32'h0);
		chk(rd, 32'h02, "disarmed status");
		cyc(AA);
		repeat (2) idle();
		bus(1'b0, 32'h08, 32'h0);
		chk(rd, 32'h0101, "store while disarmed");
	endtask : t_misc

	// Reads the timer and expects a whole-microsecond figure within one step.
	task automatic tmr_is(input logic [15:0] us);
		bus(1'b0, 32'h0C, 32'h0);
		chk(rd[18:16], 3'h0, "range");
		num_checks++;
		if ((rd[15:0] >= us - 16'd1 && rd[15:0] <= us + 16'd1) !== 1'b1)
		begin
			bad_count++;
			$display("wrong value at %0t: timer %h near %h", $time, rd[15:0], us);
		end
	endtask : tmr_is

	// Plain and restarting start/stop, then plain and restarting gated measurements.
	task automatic t_timer;
		for (int r = 0; r < 2; r++)
		begin
			arm(mk(comb_any, cap_start, 1'b0, r ? auto_restart_timing : tmr_auto), DIS, DIS, DIS);
			cyc(AA);
			repeat (1000) idle();
			cyc(AA);
			repeat (500) idle();
			cyc(AC);
			repeat (4) idle();
			tmr_is(r ? 16'd5 : 16'd15);
		end
		arm(mk(comb_any, cap_start, 1'b0, tmr_gated), DIS, DIS, DIS);
		cyc(AB);
		repeat (300) idle();
		cyc(AA);
		repeat (200) idle();
		cyc(AB);
		repeat (1000) idle();
		cyc(AC);
		repeat (4) idle();
		tmr_is(16'd10);
		// Gated restart: a second start inside the open gate begins the count again.
		arm(mk(comb_any, cap_start, 1'b0, gated_restart_timing), DIS, DIS, DIS);
		cyc(AA);
		cyc(AB);
		repeat (500) idle();
		cyc(AB);
		repeat (300) idle();
		cyc(AC);
		repeat (4) idle();
		tmr_is(16'd3);
	endtask : t_timer

	// Main sequence: reset, then every scenario.
	initial
	begin
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		bad_count = 0;
		num_checks = 0;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_count();
		t_all();
		t_ord();
		t_b2b();
		t_etb();
		t_qual();
		t_cap();
		t_misc();
		t_timer();
		wrap_up();
	end

	// Cuts a hang short.
	initial
	begin
		repeat (100000) @(posedge mclk);
		bad_count++;
		wrap_up();
	end
endmodule : cta_tb_top
